/* File: include/ovfr_pkg.sv */
package ovfr_pkg;
   // response byte layout
   localparam int          OVFR_MODE_HI   = 7;
   localparam int          OVFR_MODE_LO   = 6;
   localparam int          OVFR_RETRY_HI  = 5;
   localparam int          OVFR_RETRY_LO  = 3;
   localparam int          OVFR_DLY_HI    = 2;
   localparam int          OVFR_DLY_LO    = 0;
   localparam logic [7:0]  OVFR_CMD_CODE  = 8'h41;
   localparam logic [7:0]  OVFR_RESET_VAL = 8'hB8;
   localparam logic [7:0]  OVFR_LATCH_VAL = 8'h80;
   localparam logic [7:0]  OVFR_RETRY_VAL = 8'hB8;
   localparam logic [4:0]  OVFR_DGL_LATCH = 5'h08;   // 0x4n upper bits
   localparam logic [4:0]  OVFR_DGL_RETRY = 5'h0F;   // 0x78+n upper bits
   localparam logic [1:0]  OVFR_MODE_PULL = 2'h0;
   localparam logic [1:0]  OVFR_MODE_DGL  = 2'h1;
   localparam logic [1:0]  OVFR_MODE_OFF  = 2'h2;
   localparam logic [2:0]  OVFR_RETRY_ON  = 3'h7;
   // timing
   localparam int          OVFR_CLK_HZ    = 50_000_000;
   localparam int          OVFR_UNIT_NS   = 10_000;     // 10 us per delay unit
   localparam int          OVFR_UNIT_CYC  = OVFR_UNIT_NS / 20;
   localparam int          OVFR_RETRY_MS  = 350;
   localparam int          OVFR_RETRY_MIN_MS = 120;
   localparam longint      OVFR_RETRY_CYC =
      longint'(OVFR_RETRY_MS) * longint'(OVFR_CLK_HZ) / 1000;
   // retry interval counts in delay units (10 us)
   localparam logic [23:0] OVFR_RETRY_UNITS = 24'h0088B8; // 350 ms
endpackage

/* File: verilog/ovfr_timer.sv */
`timescale 1ns/1ns
// counts whole delay units while armed; restarts when disarmed
module ovfr_timer
   import ovfr_pkg::*;
#(
   parameter int UNIT_CYC = OVFR_UNIT_CYC,
   parameter int W        = 24
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_run,
   output logic [W-1:0]      o_units
);
   typedef struct packed {
      logic [15:0]  pre;
      logic [W-1:0] units;
   } ovfr_tmr_type;

   ovfr_tmr_type st_q, st_d;

   // prescale to units; saturate so a stuck fault cannot wrap
   always_comb begin
      st_d = st_q;
      if (!i_run) begin
         st_d = '0;
      end else if (st_q.pre == 16'(UNIT_CYC - 1)) begin
         st_d.pre = '0;
         if (st_q.units != {W{1'b1}}) begin
            st_d.units = st_q.units + 1'b1;
         end
      end else begin
         st_d.pre = st_q.pre + 16'h0001;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_units = st_q.units;
endmodule

/* File: verilog/ovfr_core.sv */
`timescale 1ns/1ns
// Operation
// - fault sets summary bit, wide summary voltage bit and overvoltage flag
// - every detected fault drives the alert output; here only overvoltage does, not a logic fault
// - 0x80 disables output, no retry, off until fault cleared
// - 0xB8 disables output and retries until run off or bias loss
// - 0x4n deglitched latch-off, released by off/on, reset or supply loss
// - 0x78+n deglitched shutdown with continuous retry
// - deglitched forms act after n times 10 us of persisting overvoltage
// - unrecognised bytes raise logic fault; stored value stays
// - mode 00 only pulls down while output exceeds the limit
// - delayed code waits bits 2:0 then applies the retry field
// - code 10 disables output at once then follows retry field
// - retry 000-110 stays off until commanded off, reset or bias loss; clear faults frees only 0x80
// - retry 111 restarts at the retry-delay interval
// - delay field counts 10 us units
// - fault bit held until clear faults, run off/on, or bias cycle; the reset command also clears it here
// - response byte per channel at code 0x41, default 0xB8
// - retry interval starts at shutdown; at least 120 ms
module ovfr_core
   import ovfr_pkg::*;
#(
   parameter logic [23:0] RETRY_UNITS = OVFR_RETRY_UNITS,
   parameter int          UNIT_CYC    = OVFR_UNIT_CYC
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_wr,
   input  wire logic [7:0] i_cmd,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_clear_faults,
   input  wire logic       i_reset_cmd,
   input  wire logic       i_op_on,
   input  wire logic       i_run_pin,
   input  wire logic       i_ov_pin,
   output logic [7:0]      o_action,
   output logic            o_summary_bit,
   output logic            o_word_vout_bit,
   output logic            o_ov_flag,
   output logic            o_logic_fault,
   output logic            o_alert_n,
   output logic            o_out_en,
   output logic            o_pull_down
);
   typedef enum {S_RUN, S_WAIT, S_OFF, S_RETRY} ovfr_st_type;

   typedef struct packed {
      logic [7:0]  action;
      logic [2:0]  ov_sync;
      logic [2:0]  run_sync;
      logic        ov;
      logic        run;
      logic        summ;
      logic        wvout;
      logic        flag;
      logic        cml;
      logic        alert_n;
      logic        en;
      logic        pd;
      ovfr_st_type st;
   } ovfr_core_type;

   ovfr_core_type s_q, s_d;

   logic [23:0] dgl_units;
   logic [23:0] rty_units;
   logic        dgl_run;
   logic        rty_run;
   logic        valid_wr;
   logic        on_now;
   logic        off_on;
   logic        ov_rise;
   logic        retry_on;
   logic [1:0]  mode;

   // deglitch timer, reset whenever overvoltage drops
   ovfr_timer #(.UNIT_CYC(UNIT_CYC), .W(24)) u_dgl (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_run   (dgl_run),
      .o_units (dgl_units)
   );

   // retry interval timer, counts from the shutdown on
   ovfr_timer #(.UNIT_CYC(UNIT_CYC), .W(24)) u_rty (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_run   (rty_run),
      .o_units (rty_units)
   );

   // recognised byte set decode
   always_comb begin
      valid_wr = (i_wdata == OVFR_LATCH_VAL) ||
                 (i_wdata == OVFR_RETRY_VAL) ||
                 (i_wdata[7:3] == OVFR_DGL_LATCH) ||
                 (i_wdata[7:3] == OVFR_DGL_RETRY);
   end

   assign mode     = s_q.action[OVFR_MODE_HI:OVFR_MODE_LO];
   assign retry_on = s_q.action[OVFR_RETRY_HI:OVFR_RETRY_LO]
                     == OVFR_RETRY_ON;
   assign on_now   = s_q.run && i_op_on;
   assign ov_rise  = s_q.ov_sync[1] && s_q.ov_sync[2] && !s_q.ov;
   // a low combined on request while output is off counts as off, then on
   assign off_on   = s_q.en == 1'b0 && !on_now;
   assign dgl_run  = s_q.ov && s_q.st == S_WAIT;
   assign rty_run  = s_q.st == S_RETRY;

   // whole channel state in one step
   always_comb begin
      s_d = s_q;
      s_d.ov_sync  = {s_q.ov_sync[1:0], i_ov_pin};
      s_d.run_sync = {s_q.run_sync[1:0], i_run_pin};
      // a change counts once stages two and three agree
      if (s_q.ov_sync[1] == s_q.ov_sync[2]) begin
         s_d.ov = s_q.ov_sync[2];
      end
      if (s_q.run_sync[1] == s_q.run_sync[2]) begin
         s_d.run = s_q.run_sync[2];
      end
      s_d.cml = 1'b0;
      if (i_wr && i_cmd == OVFR_CMD_CODE) begin
         if (valid_wr) begin
            s_d.action = i_wdata;
         end else begin
            s_d.cml = 1'b1;
         end
      end
      // pull-down follows overvoltage only in mode 00
      s_d.pd = (mode == OVFR_MODE_PULL) && s_q.ov;
      case (s_q.st)
         S_RUN: begin
            s_d.en = on_now;
            // level too, so a restart into a standing fault trips again
            if (on_now && (ov_rise || s_q.ov)) begin
               if (mode == OVFR_MODE_DGL) begin
                  s_d.st = S_WAIT;
               end else if (mode == OVFR_MODE_OFF) begin
                  s_d.en = 1'b0;
                  s_d.st = retry_on ? S_RETRY : S_OFF;
               end
            end
         end
         S_WAIT: begin
            if (!s_q.ov) begin
               s_d.st = S_RUN;
            end else if (dgl_units >=
                  24'(s_q.action[OVFR_DLY_HI:OVFR_DLY_LO])) begin
               s_d.en = 1'b0;
               s_d.st = retry_on ? S_RETRY : S_OFF;
            end
            if (!on_now) begin
               s_d.st = S_RUN;
            end
         end
         S_OFF: begin
            s_d.en = 1'b0;
            // clear frees only the 0x80 form; 0x4n waits for off/on
            if (!on_now || i_reset_cmd ||
                  (i_clear_faults && mode == OVFR_MODE_OFF)) begin
               s_d.st = S_RUN;
            end
         end
         S_RETRY: begin
            s_d.en = 1'b0;
            if (!on_now || i_reset_cmd) begin
               s_d.st = S_RUN;
            end else if (rty_units >= RETRY_UNITS) begin
               s_d.st = S_RUN;
            end
         end
         default: begin
            s_d.st = S_RUN;
         end
      endcase
      // sticky status; a new fault wins over clearing
      if (i_clear_faults || i_reset_cmd || off_on) begin
         s_d.summ  = 1'b0;
         s_d.wvout = 1'b0;
         s_d.flag  = 1'b0;
         s_d.alert_n = 1'b1;
      end
      if (ov_rise) begin
         s_d.summ  = 1'b1;
         s_d.wvout = 1'b1;
         s_d.flag  = 1'b1;
         s_d.alert_n = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s_q        <= '0;
         s_q.action <= OVFR_RESET_VAL;
         s_q.st     <= S_RUN;
         s_q.alert_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs come straight from the state register
   assign o_action        = s_q.action;
   assign o_summary_bit   = s_q.summ;
   assign o_word_vout_bit = s_q.wvout;
   assign o_ov_flag       = s_q.flag;
   assign o_logic_fault   = s_q.cml;
   assign o_alert_n       = s_q.alert_n;
   assign o_out_en        = s_q.en;
   assign o_pull_down     = s_q.pd;

   // bad byte never lands in the register
   bad_write_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_wr && i_cmd == OVFR_CMD_CODE && !valid_wr
      |=> o_logic_fault && $stable(o_action))
      else $error("rejected byte changed the response");

   // good byte lands next cycle
   good_write_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_wr && i_cmd == OVFR_CMD_CODE && valid_wr
      |=> o_action == $past(i_wdata) && !o_logic_fault)
      else $error("accepted byte not stored");

   // every overvoltage fault raises alert and status together
   fault_status_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      ov_rise |=> !o_alert_n && o_ov_flag && o_summary_bit
      && o_word_vout_bit)
      else $error("fault did not set status");

   alert_flag_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      o_ov_flag == !o_alert_n)
      else $error("alert and flag disagree");

   // immediate shutdown for code 10
   immed_off_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      s_q.st == S_RUN && on_now && ov_rise && mode == OVFR_MODE_OFF
      |=> !o_out_en)
      else $error("code 10 did not disable output");

   // mode 00 never shuts the output down
   pull_only_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      mode == OVFR_MODE_PULL && s_q.st == S_RUN |=> s_q.st != S_OFF
      && s_q.st != S_RETRY)
      else $error("pull-down mode shut down");

   // latched off holds while still commanded on
   latch_hold_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      s_q.st == S_OFF && on_now && !i_reset_cmd && !i_clear_faults
      |=> s_q.st == S_OFF && !o_out_en)
      else $error("latched off released early");

   // deglitch drops back when overvoltage goes away
   dgl_abort_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      s_q.st == S_WAIT && !s_q.ov |=> s_q.st == S_RUN)
      else $error("deglitch did not restart");

   // retry leaves only after the interval, an off request or a reset command
   retry_wait_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      s_q.st == S_RETRY && on_now && !i_reset_cmd
      && rty_units < RETRY_UNITS |=> s_q.st == S_RETRY)
      else $error("retry left early");

   // a standing fault trips again after every restart
   standing_fault_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      s_q.st == S_RUN && on_now && s_q.ov && mode == OVFR_MODE_OFF
      |=> !o_out_en)
      else $error("standing fault left output on");

   // deglitched latch-off ignores clear faults
   dgl_hold_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      s_q.st == S_OFF && mode == OVFR_MODE_DGL && on_now && !i_reset_cmd
      |=> s_q.st == S_OFF && !o_out_en)
      else $error("deglitched latch-off released early");

   // output stays on until the deglitch count is reached
   dgl_wait_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      s_q.st == S_WAIT && o_out_en
      && dgl_units < 24'(s_q.action[OVFR_DLY_HI:OVFR_DLY_LO])
      |=> o_out_en)
      else $error("deglitch shut down early");

   // count at its end with overvoltage still present shuts down
   dgl_fire_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      s_q.st == S_WAIT && s_q.ov
      && dgl_units >= 24'(s_q.action[OVFR_DLY_HI:OVFR_DLY_LO])
      |=> !o_out_en)
      else $error("deglitch end did not shut down");

   // sticky flag drops only on clear, reset command or off
   status_hold_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      o_ov_flag && !i_clear_faults && !i_reset_cmd && !off_on
      |=> o_ov_flag)
      else $error("fault flag dropped without a clear");

   // retry ends once the interval has run out
   retry_end_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      s_q.st == S_RETRY && rty_units >= RETRY_UNITS
      |=> s_q.st == S_RUN)
      else $error("retry did not restart");

   // logic fault only follows a write to this register
   fault_cause_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      !(i_wr && i_cmd == OVFR_CMD_CODE)
      |=> !o_logic_fault)
      else $error("logic fault without a write");
endmodule

/* File: testbench/ovfr_host.sv */
`timescale 1ns/1ns
// bus host model: writes one response byte per call
module ovfr_host
   import ovfr_pkg::*;
(
   input  wire logic       i_clk,
   output logic            o_wr,
   output logic [7:0]      o_cmd,
   output logic [7:0]      o_wdata
);
   initial begin
      o_wr = 1'b0;
      o_cmd = 8'h00;
      o_wdata = 8'h00;
   end

   // one-cycle strobe; bus shows inverse data once released
   task automatic write(input logic [7:0] b);
      @(negedge i_clk);
      o_wr = 1'b1;
      o_cmd = OVFR_CMD_CODE;
      o_wdata = b;
      @(negedge i_clk);
      o_wr = 1'b0;
      o_cmd = ~o_cmd;
      o_wdata = ~b;
   endtask
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
module testbench
   import ovfr_pkg::*;
;
   logic       clk, rst, clr, rcmd, op_on, run, ov, wr;
   logic [7:0] cmd, wdata, action;
   logic       sum, wvb, ovf, lf, alert_n, out_en, pd, f;
   int         fails, compares, cyc;
   logic [7:0] good [6] = '{8'h80, 8'h40, 8'h47, 8'h78, 8'h7F, 8'hB8};
   logic [7:0] bad [6] = '{8'h00, 8'hC0, 8'h48, 8'h77, 8'hB9, 8'h3F};

   // short units keep the retry and deglitch waits small
   ovfr_core #(.RETRY_UNITS(24'h000004), .UNIT_CYC(4)) u_ovfr_core (
      .i_clk(clk), .i_rst(rst), .i_wr(wr), .i_cmd(cmd), .i_wdata(wdata),
      .i_clear_faults(clr), .i_reset_cmd(rcmd), .i_op_on(op_on),
      .i_run_pin(run), .i_ov_pin(ov), .o_action(action),
      .o_summary_bit(sum), .o_word_vout_bit(wvb), .o_ov_flag(ovf),
      .o_logic_fault(lf), .o_alert_n(alert_n), .o_out_en(out_en),
      .o_pull_down(pd));
   ovfr_host u_ovfr_host (.i_clk(clk), .o_wr(wr), .o_cmd(cmd),
      .o_wdata(wdata));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic tally_and_finish();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         tally_and_finish();
      end
   end

   task automatic check(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask

   // bounded wait for the output enable, then judge it
   task automatic wait_en(input logic v, input int lim);
      int n;
      n = 0;
      while (out_en !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      check("out_en", {7'h00, v}, {7'h00, out_en});
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic t_writes();
      foreach (bad[i]) begin
         u_ovfr_host.write(bad[i]);
         f = lf;
         idle(1);
         check("fault", 8'h01, {7'h00, f | lf});
         check("action", OVFR_RESET_VAL, action);
      end
      foreach (good[i]) begin
         u_ovfr_host.write(good[i]);
         f = lf;
         idle(1);
         check("fault", 8'h00, {7'h00, f});
         check("action", good[i], action);
      end
   endtask

   task automatic t_latch();
      run = 1'b1;
      op_on = 1'b1;
      wait_en(1'b1, 20);
      u_ovfr_host.write(OVFR_LATCH_VAL);
      ov = 1'b1;
      wait_en(1'b0, 20);
      idle(2);
      check("status", 8'h07, {5'h00, sum, wvb, ovf});
      check("alert_n", 8'h00, {7'h00, alert_n});
      ov = 1'b0;
      idle(40);
      check("out_en", 8'h00, {7'h00, out_en});
      clr = 1'b1;
      idle(1);
      clr = 1'b0;
      idle(2);
      check("status", 8'h01, {4'h0, sum, wvb, ovf, alert_n});
      wait_en(1'b1, 30);
   endtask

   task automatic t_retry();
      u_ovfr_host.write(OVFR_RETRY_VAL);
      ov = 1'b1;
      wait_en(1'b0, 20);
      // fault still standing across about two retry intervals
      idle(40);
      check("out_en", 8'h00, {7'h00, out_en});
      ov = 1'b0;
      idle(4);
      check("out_en", 8'h00, {7'h00, out_en});
      wait_en(1'b1, 40);
   endtask

   task automatic t_dgl_latch();
      u_ovfr_host.write(8'h43);
      ov = 1'b1;
      idle(6);
      ov = 1'b0;
      idle(20);
      check("out_en", 8'h01, {7'h00, out_en});
      ov = 1'b1;
      idle(10);
      check("out_en", 8'h01, {7'h00, out_en});
      wait_en(1'b0, 20);
      ov = 1'b0;
      idle(40);
      check("out_en", 8'h00, {7'h00, out_en});
      clr = 1'b1;
      idle(1);
      clr = 1'b0;
      idle(2);
      check("out_en", 8'h00, {7'h00, out_en});
      run = 1'b0;
      idle(10);
      check("status", 8'h01, {4'h0, sum, wvb, ovf, alert_n});
      run = 1'b1;
      wait_en(1'b1, 30);
   endtask

   task automatic t_dgl_retry();
      u_ovfr_host.write(8'h79);
      ov = 1'b1;
      wait_en(1'b0, 30);
      check("alert_n", 8'h00, {7'h00, alert_n});
      check("pull", 8'h00, {7'h00, pd});
      ov = 1'b0;
      wait_en(1'b1, 40);
      rcmd = 1'b1;
      idle(1);
      rcmd = 1'b0;
      idle(2);
      check("status", 8'h01, {4'h0, sum, wvb, ovf, alert_n});
   endtask

   initial begin
      rst = 1'b1;
      clr = 1'b0;
      rcmd = 1'b0;
      op_on = 1'b0;
      run = 1'b0;
      ov = 1'b0;
      idle(8);
      rst = 1'b0;
      idle(1);
      check("action", OVFR_RESET_VAL, action);
      check("state", 8'h01, {3'h0, out_en, sum, wvb, ovf, alert_n});
      t_writes();
      t_latch();
      t_retry();
      t_dgl_latch();
      t_dgl_retry();
      tally_and_finish();
   end
endmodule
